// *** fp_load_store_formatter.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - address is base plus sign-extended displacement
// - misaligned address raises alignment exception
// - legacy single load field order
// - single loads widen 8-bit exponent to 11
// - legacy double load swaps 16-bit words
// - ieee single load field order
// - longword in register layout, low zeros
// - ieee double load copies unchanged
// - legacy single store field order
// - legacy single store ignores bits, no checks
// - legacy double store swaps 16-bit words
// - ieee single store packs bits 63:62,58:29
// - loads report access, read, translation faults
// - stores report access, write, translation faults
// - legacy ops only in legacy subset
// - bits move without interpretation or traps
module fp_load_store_formatter (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid, // one-cycle request pulse
  input wire logic [2:0] req_op, // operation code
  input wire logic [63:0] base_integer_register, // base value
  input wire logic [15:0] req_disp, // displacement field
  input wire logic [63:0] float_data_register, // store source
  input wire logic legacy_subset_en, // legacy formats present
  output logic mem_req, // memory request pulse
  output logic mem_write, // store when high
  output logic mem_quad, // quadword size when high
  output logic [63:0] mem_addr, // virtual address
  output logic [63:0] mem_wdata, // store data, memory layout
  input wire logic mem_ack, // memory answer pulse
  input wire logic [63:0] mem_rdata, // load data
  input wire logic mem_acc_viol, // access violation
  input wire logic mem_fault_rw, // fault on read or write
  input wire logic mem_tnv, // translation not valid
  output logic done, // completion pulse
  output logic [63:0] load_result, // register value for loads
  output logic load_we, // write register file
  output logic [2:0] fault // fault code with done
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MEM = 4'h2,
    ST_WIDEN = 4'h4,
    ST_DONE = 4'h8
  } state_e;

  state_e state_r, state_nxt; // sequencer state
  logic [2:0] op_r, op_nxt; // held operation
  logic [63:0] addr_r, addr_nxt; // held address
  logic [63:0] wdata_r, wdata_nxt; // store data
  logic [63:0] rdata_r, rdata_nxt; // captured load data
  logic [63:0] result_r, result_nxt; // load result
  logic mem_req_r, mem_req_nxt;
  logic done_r, done_nxt;
  logic we_r, we_nxt;
  logic [2:0] fault_r, fault_nxt;
  logic quad_r, quad_nxt; // quadword size of the held operation
  logic [7:0] exp_in; // exponent fed to widener
  logic [10:0] exp_wide; // widened exponent, one cycle later
  logic [63:0] va; // computed address

  // true for quadword-sized operations
  function automatic logic is_quad(input logic [2:0] op);
    is_quad = (op == fp_ls_pkg::OP_LOAD_LEGACY_DOUBLE) ||
      (op == fp_ls_pkg::OP_LOAD_IEEE_DOUBLE) ||
      (op == fp_ls_pkg::OP_STORE_LEGACY_DOUBLE) ||
      (op == fp_ls_pkg::OP_STORE_IEEE_DOUBLE);
  endfunction

  // true for legacy-only operations
  function automatic logic is_legacy(input logic [2:0] op);
    is_legacy = (op == fp_ls_pkg::OP_LOAD_LEGACY_SINGLE) ||
      (op == fp_ls_pkg::OP_LOAD_LEGACY_DOUBLE) ||
      (op == fp_ls_pkg::OP_STORE_LEGACY_SINGLE) ||
      (op == fp_ls_pkg::OP_STORE_LEGACY_DOUBLE);
  endfunction

  // swap the four 16-bit words end for end
  function automatic logic [63:0] swap_words(input logic [63:0] d);
    swap_words = {d[15:0], d[31:16], d[47:32], d[63:48]};
  endfunction

  // address adder
  assign va = base_integer_register +
    {{(64 - fp_ls_pkg::DISP_W){req_disp[15]}}, req_disp};

  // exponent source depends on single format
  assign exp_in = (op_r == fp_ls_pkg::OP_LOAD_LEGACY_SINGLE) ?
    rdata_r[14:7] : rdata_r[30:23];

  fp_exp_widen u_widen (
    .clock(clock),
    .rst(rst),
    .exp_in(exp_in),
    .exp_out(exp_wide)
  );

  // sequencer next-state and datapath
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    result_nxt = result_r;
    mem_req_nxt = 1'b0;
    done_nxt = 1'b0;
    we_nxt = 1'b0;
    fault_nxt = fault_r;
    quad_nxt = quad_r;
    case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          op_nxt = req_op;
          addr_nxt = va;
          quad_nxt = is_quad(req_op); // size output comes from a flop
          // store reordering, no value
          case (req_op)
            fp_ls_pkg::OP_STORE_LEGACY_SINGLE: begin
              wdata_nxt = {32'h0, float_data_register[44:29],
                float_data_register[63:62],
                float_data_register[58:45]};
            end
            fp_ls_pkg::OP_STORE_LEGACY_DOUBLE: begin
              wdata_nxt = swap_words(float_data_register);
            end
            fp_ls_pkg::OP_STORE_IEEE_SINGLE: begin
              wdata_nxt = {32'h0, float_data_register[63:62],
                float_data_register[58:29]};
            end
            default: begin
              wdata_nxt = float_data_register;
            end
          endcase
          if (is_legacy(req_op) && !legacy_subset_en) begin
            fault_nxt = fp_ls_pkg::FLT_SUBSET;
            state_nxt = ST_DONE;
          end else if ((va[2:0] & (is_quad(req_op) ?
              fp_ls_pkg::ALIGN_QUAD_MASK :
              fp_ls_pkg::ALIGN_LONG_MASK)) != 3'h0) begin
            fault_nxt = fp_ls_pkg::FLT_ALIGN;
            state_nxt = ST_DONE;
          end else begin
            fault_nxt = fp_ls_pkg::FLT_NONE;
            mem_req_nxt = 1'b1;
            state_nxt = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        // wait for memory answer, classify faults
        if (mem_ack) begin
          rdata_nxt = mem_rdata;
          if (mem_acc_viol) begin
            fault_nxt = fp_ls_pkg::FLT_ACCESS;
          end else if (mem_fault_rw) begin
            fault_nxt = op_r[2] ? fp_ls_pkg::FLT_ON_WRITE :
              fp_ls_pkg::FLT_ON_READ;
          end else if (mem_tnv) begin
            fault_nxt = fp_ls_pkg::FLT_TNV;
          end
          state_nxt = (!op_r[2] && !mem_acc_viol && !mem_fault_rw &&
            !mem_tnv) ? ST_WIDEN : ST_DONE;
        end
      end
      ST_WIDEN: begin
        // widener registers the exponent here; register value is built in ST_DONE
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (fault_r == fp_ls_pkg::FLT_NONE && !op_r[2]) begin
          case (op_r)
            fp_ls_pkg::OP_LOAD_LEGACY_SINGLE: begin
              result_nxt = {rdata_r[15], exp_wide, rdata_r[6:0],
                rdata_r[31:16], 29'h0};
            end
            fp_ls_pkg::OP_LOAD_LEGACY_DOUBLE: begin
              result_nxt = swap_words(rdata_r);
            end
            fp_ls_pkg::OP_LOAD_IEEE_SINGLE: begin
              result_nxt = {rdata_r[31], exp_wide, rdata_r[22:0],
                29'h0};
            end
            default: begin
              result_nxt = rdata_r;
            end
          endcase
          we_nxt = 1'b1;
        end
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_r <= 3'h0;
      addr_r <= 64'h0;
      wdata_r <= 64'h0;
      rdata_r <= 64'h0;
      result_r <= 64'h0;
      mem_req_r <= 1'b0;
      done_r <= 1'b0;
      we_r <= 1'b0;
      fault_r <= fp_ls_pkg::FLT_NONE;
      quad_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      result_r <= result_nxt;
      mem_req_r <= mem_req_nxt;
      done_r <= done_nxt;
      we_r <= we_nxt;
      fault_r <= fault_nxt;
      quad_r <= quad_nxt;
    end
  end

  assign mem_req = mem_req_r;
  assign mem_write = op_r[2];
  assign mem_quad = quad_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign done = done_r;
  assign load_result = result_r;
  assign load_we = we_r;
  assign fault = fault_r;

  // misaligned request never reaches memory
  chk_align_no_mem: assert property (
    @(posedge clock) disable iff (rst)
    state_r == ST_IDLE && req_valid &&
    (legacy_subset_en || !is_legacy(req_op)) &&
    (va[2:0] & (is_quad(req_op) ? fp_ls_pkg::ALIGN_QUAD_MASK :
    fp_ls_pkg::ALIGN_LONG_MASK)) != 3'h0 |=>
    !mem_req ##1 done && fault == fp_ls_pkg::FLT_ALIGN)
    else $error("misaligned access went to memory");
  // address equals base plus displacement
  chk_addr_form: assert property (
    @(posedge clock) disable iff (rst)
    state_r == ST_IDLE && req_valid |=> mem_addr ==
    $past(base_integer_register) + {{48{$past(req_disp[15])}},
    $past(req_disp)})
    else $error("address not base plus displacement");
  // ieee double load copies data unchanged
  chk_double_copy: assert property (
    @(posedge clock) disable iff (rst)
    load_we && op_r == fp_ls_pkg::OP_LOAD_IEEE_DOUBLE |->
    load_result == rdata_r)
    else $error("ieee double load altered data");
  // single loads have low 29 bits zero
  chk_single_low: assert property (
    @(posedge clock) disable iff (rst)
    load_we && !mem_quad |-> load_result[28:0] == 29'h0)
    else $error("single load low bits not zero");
  // legacy double load swaps words
  chk_ldouble_swap: assert property (
    @(posedge clock) disable iff (rst)
    load_we && op_r == fp_ls_pkg::OP_LOAD_LEGACY_DOUBLE |->
    load_result[63:48] == rdata_r[15:0])
    else $error("legacy double word order wrong");
  // legacy ops refused outside legacy subset
  chk_subset_refuse: assert property (
    @(posedge clock) disable iff (rst)
    state_r == ST_IDLE && req_valid && !legacy_subset_en &&
    is_legacy(req_op) |-> ##2 done && fault == fp_ls_pkg::FLT_SUBSET)
    else $error("legacy op not refused");
  // store fault on write reported as write fault
  chk_store_fault: assert property (
    @(posedge clock) disable iff (rst)
    state_r == ST_MEM && mem_ack && op_r[2] && !mem_acc_viol &&
    mem_fault_rw |-> ##2 done && fault == fp_ls_pkg::FLT_ON_WRITE)
    else $error("store fault code wrong");
  // load translation fault reported, no register write
  chk_load_tnv: assert property (
    @(posedge clock) disable iff (rst)
    state_r == ST_MEM && mem_ack && !op_r[2] && !mem_acc_viol &&
    !mem_fault_rw && mem_tnv |-> ##2 done && !load_we &&
    fault == fp_ls_pkg::FLT_TNV)
    else $error("load tnv not reported");
  cov_load: cover property (@(posedge clock) load_we);
  cov_store: cover property (@(posedge clock) done && mem_write &&
    fault == fp_ls_pkg::FLT_NONE);
  cov_align: cover property (@(posedge clock)
    fault == fp_ls_pkg::FLT_ALIGN && done);
endmodule
`default_nettype wire

// *** fp_ls_pkg.sv ***
package fp_ls_pkg;
  // operation codes presented by the pipeline
  localparam logic [2:0] OP_LOAD_LEGACY_SINGLE = 3'h0;
  localparam logic [2:0] OP_LOAD_LEGACY_DOUBLE = 3'h1;
  localparam logic [2:0] OP_LOAD_IEEE_SINGLE = 3'h2;
  localparam logic [2:0] OP_LOAD_IEEE_DOUBLE = 3'h3;
  localparam logic [2:0] OP_STORE_LEGACY_SINGLE = 3'h4;
  localparam logic [2:0] OP_STORE_LEGACY_DOUBLE = 3'h5;
  localparam logic [2:0] OP_STORE_IEEE_SINGLE = 3'h6;
  localparam logic [2:0] OP_STORE_IEEE_DOUBLE = 3'h7;
  // fault codes reported with done
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_ALIGN = 3'h1;
  localparam logic [2:0] FLT_ACCESS = 3'h2;
  localparam logic [2:0] FLT_ON_READ = 3'h3;
  localparam logic [2:0] FLT_ON_WRITE = 3'h4;
  localparam logic [2:0] FLT_TNV = 3'h5;
  localparam logic [2:0] FLT_SUBSET = 3'h6;
  // exponent widths and bias difference
  localparam int EXP_MEM_W = 8;
  localparam int EXP_REG_W = 11;
  localparam logic [10:0] EXP_BIAS_DIFF = 11'h380;
  // alignment masks on the low address bits
  localparam logic [2:0] ALIGN_LONG_MASK = 3'h3;
  localparam logic [2:0] ALIGN_QUAD_MASK = 3'h7;
  localparam int DISP_W = 16;
endpackage

// *** fp_exp_widen.sv ***
`timescale 1ns/1ps
`default_nettype none
// registered exponent widening, one cycle latency
module fp_exp_widen (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] exp_in,
  output logic [10:0] exp_out
);
  logic [10:0] exp_r; // widened exponent
  logic [10:0] exp_nxt; // next value

  // all ones stay all ones, zero stays zero, others rebias
  always_comb begin
    if (exp_in == 8'hff) begin
      exp_nxt = 11'h7ff;
    end else if (exp_in == 8'h00) begin
      exp_nxt = 11'h000;
    end else begin
      exp_nxt = {3'h0, exp_in} + fp_ls_pkg::EXP_BIAS_DIFF;
    end
  end

  // register stage
  always_ff @(posedge clock) begin
    if (rst) begin
      exp_r <= 11'h000;
    end else begin
      exp_r <= exp_nxt;
    end
  end

  assign exp_out = exp_r;
endmodule
`default_nettype wire

// *** fp_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// memory and translation stand-in: one answer per request, set delay
module fp_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [63:0] rdata_cfg,
  input wire logic [1:0] flt_cfg,
  input wire logic [3:0] dly_cfg,
  output logic mem_ack = 1'b0,
  output logic [63:0] mem_rdata = 64'h0,
  output logic mem_acc_viol = 1'b0,
  output logic mem_fault_rw = 1'b0,
  output logic mem_tnv = 1'b0
);
  logic pend_r; // a request waits for its answer
  logic [3:0] cnt_r; // cycles left before the answer
  // flags only beside ack; data line toggles so stale data never matches
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_acc_viol <= 1'b0;
    mem_fault_rw <= 1'b0;
    mem_tnv <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      pend_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (pend_r && cnt_r == 4'h0) begin
      pend_r <= 1'b0;
      mem_ack <= 1'b1;
      mem_rdata <= rdata_cfg;
      mem_acc_viol <= (flt_cfg == 2'h1);
      mem_fault_rw <= (flt_cfg == 2'h2);
      mem_tnv <= (flt_cfg == 2'h3);
    end else if (pend_r) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (mem_req) begin
      pend_r <= 1'b1;
      cnt_r <= dly_cfg;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// bench for the floating load/store formatter
module tb_top;
  logic clock, rst, req_valid, legacy_subset_en, mem_req, mem_write;
  logic mem_quad, mem_ack, mem_acc_viol, mem_fault_rw, mem_tnv, done;
  logic load_we;
  logic [2:0] req_op, fault;
  logic [15:0] req_disp;
  logic [63:0] base_integer_register, float_data_register, mem_addr;
  logic [63:0] mem_wdata, mem_rdata, load_result, rdata_cfg;
  logic [1:0] flt_cfg; // answer kind: clean, access, read/write, tnv
  logic [3:0] dly_cfg; // answer delay
  logic [63:0] v [5]; // shared data patterns
  int mismatches, comparisons, cyc, ack_cyc, mreq_cyc, nreq;

  fp_load_store_formatter fp_load_store_formatter_i (.clock(clock),
    .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .base_integer_register(base_integer_register), .req_disp(req_disp),
    .float_data_register(float_data_register),
    .legacy_subset_en(legacy_subset_en), .mem_req(mem_req),
    .mem_write(mem_write), .mem_quad(mem_quad), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_acc_viol(mem_acc_viol), .mem_fault_rw(mem_fault_rw),
    .mem_tnv(mem_tnv), .done(done), .load_result(load_result),
    .load_we(load_we), .fault(fault));
  fp_mem_model fp_mem_model_i (.clock(clock), .rst(rst), .mem_req(mem_req),
    .rdata_cfg(rdata_cfg), .flt_cfg(flt_cfg), .dly_cfg(dly_cfg),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_acc_viol(mem_acc_viol),
    .mem_fault_rw(mem_fault_rw), .mem_tnv(mem_tnv));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // cycle index plus answer and request bookkeeping
  always @(posedge clock) begin
    cyc = cyc + 1;
    #1;
    if (mem_ack === 1'b1) ack_cyc = cyc;
    if (mem_req === 1'b1) begin
      nreq = nreq + 1;
      mreq_cyc = cyc;
    end
  end

  task automatic chk(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // exponent widening: all-ones and zero kept, others rebiased
  function automatic logic [10:0] widen(input logic [7:0] e);
    if (e == 8'hff) return 11'h7ff;
    if (e == 8'h00) return 11'h000;
    return {3'h0, e} + fp_ls_pkg::EXP_BIAS_DIFF;
  endfunction

  // expected register or memory image per operation
  function automatic logic [63:0] expect_of(input logic [2:0] op,
    input logic [63:0] d);
    case (op)
      3'h0: return {d[15], widen(d[14:7]), d[6:0], d[31:16], 29'h0};
      3'h2: return {d[31], widen(d[30:23]), d[22:0], 29'h0};
      3'h1, 3'h5: return {d[15:0], d[31:16], d[47:32], d[63:48]};
      3'h4: return {32'h0, d[44:29], d[63:62], d[58:45]};
      3'h6: return {32'h0, d[63:62], d[58:29]};
      default: return d;
    endcase
  endfunction

  // one request, wait for done, judge fault, timing, address and data
  task automatic run_op(input logic [2:0] op, input logic [15:0] disp,
    input logic [63:0] d, input logic [1:0] flt, input logic poke);
    int n, rc;
    logic ld, ok, refused;
    logic [2:0] ef;
    logic [63:0] addr, wd;
    ld = ~op[2];
    addr = base_integer_register + {{48{disp[15]}}, disp};
    ef = fp_ls_pkg::FLT_NONE;
    if (!legacy_subset_en && !op[1]) begin
      ef = fp_ls_pkg::FLT_SUBSET;
    end else if (op[0] ? addr[2:0] != 3'h0 : addr[1:0] != 2'h0) begin
      ef = fp_ls_pkg::FLT_ALIGN;
    end else if (flt == 2'h1) begin
      ef = fp_ls_pkg::FLT_ACCESS;
    end else if (flt == 2'h2) begin
      ef = ld ? fp_ls_pkg::FLT_ON_READ : fp_ls_pkg::FLT_ON_WRITE;
    end else if (flt == 2'h3) begin
      ef = fp_ls_pkg::FLT_TNV;
    end
    ok = (ef == fp_ls_pkg::FLT_NONE);
    refused = (ef == fp_ls_pkg::FLT_ALIGN || ef == fp_ls_pkg::FLT_SUBSET);
    rdata_cfg = d;
    float_data_register = d;
    flt_cfg = flt;
    dly_cfg = {1'b0, op};
    req_op = op;
    req_disp = disp;
    nreq = 0;
    req_valid = 1'b1;
    rc = cyc;
    @(posedge clock);
    #2 req_valid = poke; // a request while busy must be dropped
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #2;
      if (req_valid) req_valid = 1'b0; // only the busy-time poke is lowered
      n++;
    end
    wd = op[0] ? mem_wdata : {32'h0, mem_wdata[31:0]};
    chk("done", done, 64'h1);
    chk("fault", fault, ef);
    chk("load_we", load_we, ld && ok);
    if (refused) begin
      chk("refuse_time", cyc - rc, 2);
      chk("mem_reqs", nreq, 0);
    end else begin
      chk("mem_reqs", nreq, 1);
      chk("req_time", mreq_cyc - rc, 1);
      chk("addr", mem_addr, addr);
      chk("dir_size", {mem_write, mem_quad}, {~ld, op[0]});
      chk("answer_time", cyc - ack_cyc, (ld && ok) ? 3 : 2);
      if (ok && ld) chk("load", load_result, expect_of(op, d));
      if (ok && !ld) chk("store", wd, expect_of(op, d));
    end
  endtask

  // every load format, exponent all-ones, zero and middle
  task automatic t_loads();
    for (int j = 0; j < 20; j++) begin
      run_op(3'(j % 4), 16'hfff0, v[j / 4], 2'h0, 1'b0);
    end
  endtask

  // every store format, ignored bits set, longwords at offset 4
  task automatic t_stores();
    for (int j = 0; j < 8; j++) begin
      run_op(3'(4 + j % 4), j[0] ? 16'h0008 : 16'h000c, v[j % 3], 2'h0,
        1'b0);
    end
  endtask

  // misaligned longword at 2, quadword at 4, each refused
  task automatic t_align();
    for (int j = 0; j < 8; j++) begin
      run_op(3'(j), j[0] ? 16'h0004 : 16'h0002, v[0], 2'h0, 1'b0);
    end
  endtask

  // each memory fault on a load and a store, with a busy-time request
  task automatic t_faults();
    for (int j = 0; j < 6; j++) begin
      run_op(j < 3 ? 3'h2 : 3'h7, 16'h0008, v[1], 2'(1 + j % 3), 1'b1);
    end
  endtask

  // legacy formats refused with the subset off, ieee formats still run
  task automatic t_subset();
    legacy_subset_en = 1'b0;
    for (int j = 0; j < 8; j++) begin
      run_op(3'(j), 16'h0008, v[2], 2'h0, 1'b0);
    end
    legacy_subset_en = 1'b1;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #(25 * 4000);
    mismatches++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    legacy_subset_en = 1'b1;
    req_op = 3'h0;
    req_disp = 16'h0;
    base_integer_register = 64'h0001_0000_0000_0100;
    float_data_register = 64'h0;
    rdata_cfg = 64'h0;
    flt_cfg = 2'h0;
    dly_cfg = 4'h0;
    v = '{64'hdead_beef_a5c3_7fd2, 64'h3bcd_ef01_89ab_8055,
      64'hc7ff_ba98_7f80_ffff, 64'h8000_0001_4000_4080,
      64'h1111_2222_8000_8000};
    repeat (5) @(posedge clock);
    #2 rst = 1'b0;
    chk("idle", {mem_req, done, load_we, fault}, 64'h0);
    t_loads();
    t_stores();
    t_align();
    t_faults();
    t_subset();
    summarize();
  end
endmodule
`default_nettype wire
